//--- core/ccd_defines.svh
// Register offsets, field positions, reset values for the channel divider.
`ifndef CCD_DEFINES_SVH
`define CCD_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CCD_ADDR_W 10
`define CCD_ADDR_CH1_CNT 10'h193
`define CCD_ADDR_CH1_DIV 10'h194
`define CCD_ADDR_CH1_OUT 10'h195
`define CCD_ADDR_CH2_CNT 10'h196
`define CCD_ADDR_CH2_DIV 10'h197

// ****************************************************************
// Reset values
// ****************************************************************
`define CCD_RST_CH1_CNT 8'h33
`define CCD_RST_CH1_DIV 8'h00
`define CCD_RST_CH1_OUT 8'h00
`define CCD_RST_CH2_CNT 8'h11
`define CCD_RST_CH2_DIV 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define CCD_CNT_LOW_HI 7
`define CCD_CNT_LOW_LO 4
`define CCD_CNT_HIGH_HI 3
`define CCD_CNT_HIGH_LO 0
`define CCD_DIV_BYPASS 7
`define CCD_DIV_IGNORE 6
`define CCD_DIV_FORCE 5
`define CCD_DIV_START 4
`define CCD_DIV_PHASE_HI 3
`define CCD_DIV_PHASE_LO 0
`define CCD_OUT_PDOWN 2
`define CCD_OUT_DIRECT 1
`define CCD_OUT_DCC_DIS 0
`define CCD_OUT_USED_MASK 8'h07

`endif

//--- core/ccd_pkg.sv
// Types shared by the channel clock divider files.
package ccd_pkg;

    // Divider sequencer states, Gray coded along hold, delay, low, high.
    typedef enum logic [1:0] {
        CCD_HOLD  = 2'b00,
        CCD_DELAY = 2'b01,
        CCD_LOW   = 2'b11,
        CCD_HIGH  = 2'b10
    } ccd_div_state_t;

endpackage : ccd_pkg

//--- core/ccd_sync2.sv
// Two flip-flop synchroniser for one asynchronous level.
`timescale 1ns/1ps
`default_nettype none
module ccd_sync2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rst_val,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb
    begin
        meta_d = async_in ~^ rst_val;
        sync_d = meta_q;
    end

    // Flops store the input relative to rst_val, so they reset to constants.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q ~^ rst_val;
endmodule : ccd_sync2
`default_nettype wire

//--- core/ccd_divider.sv
// Programmable low/high phase divider with alignment, force and bypass.
`timescale 1ns/1ps
`default_nettype none
module ccd_divider
    import ccd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_img,
    input wire logic [3:0] low_cnt,
    input wire logic [3:0] high_cnt,
    input wire logic bypass,
    input wire logic ignore_align,
    input wire logic force_on,
    input wire logic start_high,
    input wire logic [3:0] phase,
    input wire logic align,
    output logic div_out
);
    ccd_div_state_t state_q;
    ccd_div_state_t state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic out_q;
    logic out_d;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        out_d = out_q;
        if (bypass)
        begin
            // R3: bypass passes input
            // R6: force ignored here
            state_d = CCD_HOLD;
            cnt_d = 4'h0;
            out_d = clk_img;
        end
        else if (ignore_align)
        begin
            // R4: alignment disregarded
            // R5: forced static level
            state_d = CCD_HOLD;
            cnt_d = 4'h0;
            out_d = force_on ? start_high : 1'b0;
        end
        else if (align)
        begin
            // R4: alignment holds divider
            state_d = CCD_HOLD;
            cnt_d = 4'h0;
            out_d = start_high;
        end
        else
        begin
            unique case (state_q)
                CCD_HOLD:
                begin
                    // R8: phase offset delay
                    state_d = CCD_DELAY;
                    cnt_d = phase;
                    out_d = start_high;
                end
                CCD_DELAY:
                begin
                    if (cnt_q != 4'h0)
                    begin
                        cnt_d = cnt_q - 4'h1;
                    end
                    else
                    begin
                        // R7: selected starting level
                        state_d = start_high ? CCD_HIGH : CCD_LOW;
                        cnt_d = start_high ? high_cnt : low_cnt;
                        out_d = start_high;
                    end
                end
                CCD_LOW:
                begin
                    if (cnt_q != 4'h0)
                    begin
                        cnt_d = cnt_q - 4'h1;
                    end
                    else
                    begin
                        // R1: high for count plus one
                        // R15: phases alternate
                        state_d = CCD_HIGH;
                        cnt_d = high_cnt;
                        out_d = 1'b1;
                    end
                end
                CCD_HIGH:
                begin
                    if (cnt_q != 4'h0)
                    begin
                        cnt_d = cnt_q - 4'h1;
                    end
                    else
                    begin
                        // R2: low for count plus one
                        state_d = CCD_LOW;
                        cnt_d = low_cnt;
                        out_d = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= CCD_HOLD;
            cnt_q <= 4'h0;
            out_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    assign div_out = out_q;
endmodule : ccd_divider
`default_nettype wire

//--- core/ccd_top.sv
// Channel clock divider: registers, two dividers and channel 1 routing.
//
// Behaviour
// R1: Channel 1 output stays high for high count plus one; resets to 0x3.
// R2: Channel 1 output stays low for low count plus one; resets to 0x3.
// R3: Bypass bit set powers divider down and passes input clock through.
// R4: Ignore bit clear obeys alignment signal; set disregards it entirely.
// R5: Force bit, with ignore set, forces low or the start-high level.
// R6: Force has no effect when bypassed; driver inversion still works.
// R7: Start-high bit picks the level the clock begins at after alignment.
// R8: Four-bit phase offset delays the start after alignment; resets to zero.
// R9: Channel power-down puts all three drivers into safe off state.
// R10: Direct-route bit sends input clock to drivers unless blocked.
// R11: Duty-cycle correction applies unless its disable bit is set; the code also turns it off while power-down is set.
// R12: Channel 2 low phase is count plus one cycles; resets to 0x1.
// R13: Channel 2 high phase is count plus one cycles; resets to 0x1.
// R14: Control register bits 7 to 3 are unused and read zero.
// R15: Divided period is low plus high lengths, alternating continuously.
`timescale 1ns/1ps
`default_nettype none
`include "ccd_defines.svh"
module ccd_top
    import ccd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic align_req_n,
    input wire logic direct_route_block,
    input wire logic [2:0] driver_invert,
    output logic group1_driver_a,
    output logic group1_driver_b,
    output logic group1_driver_c,
    output logic group1_driver_en,
    output logic duty_cycle_correction,
    output logic channel2_div_out
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [7:0] ch1_cnt_q;
    logic [7:0] ch1_cnt_d;
    logic [7:0] ch1_div_q;
    logic [7:0] ch1_div_d;
    logic [7:0] ch1_out_q;
    logic [7:0] ch1_out_d;
    logic [7:0] ch2_cnt_q;
    logic [7:0] ch2_cnt_d;
    logic [7:0] ch2_div_q;
    logic [7:0] ch2_div_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb
    begin
        ch1_cnt_d = ch1_cnt_q;
        ch1_div_d = ch1_div_q;
        ch1_out_d = ch1_out_q;
        ch2_cnt_d = ch2_cnt_q;
        ch2_div_d = ch2_div_q;
        if (reg_wr)
        begin
            unique case (reg_addr)
                `CCD_ADDR_CH1_CNT:
                begin
                    ch1_cnt_d = reg_wdata;
                end
                `CCD_ADDR_CH1_DIV:
                begin
                    ch1_div_d = reg_wdata;
                end
                `CCD_ADDR_CH1_OUT:
                begin
                    // R14: unused bits dropped
                    ch1_out_d = reg_wdata & `CCD_OUT_USED_MASK;
                end
                `CCD_ADDR_CH2_CNT:
                begin
                    ch2_cnt_d = reg_wdata;
                end
                `CCD_ADDR_CH2_DIV:
                begin
                    ch2_div_d = reg_wdata;
                end
                default:
                begin
                    ch1_cnt_d = ch1_cnt_q;
                end
            endcase
        end
    end

    // Reads return the value held before a write in the same cycle.
    always_comb
    begin
        rdata_d = rdata_q;
        if (reg_rd)
        begin
            unique case (reg_addr)
                `CCD_ADDR_CH1_CNT:
                begin
                    rdata_d = ch1_cnt_q;
                end
                `CCD_ADDR_CH1_DIV:
                begin
                    rdata_d = ch1_div_q;
                end
                `CCD_ADDR_CH1_OUT:
                begin
                    // R14: unused bits read zero
                    rdata_d = ch1_out_q & `CCD_OUT_USED_MASK;
                end
                `CCD_ADDR_CH2_CNT:
                begin
                    rdata_d = ch2_cnt_q;
                end
                `CCD_ADDR_CH2_DIV:
                begin
                    rdata_d = ch2_div_q;
                end
                default:
                begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // R1: high count resets to 0x3
            // R2: low count resets to 0x3
            ch1_cnt_q <= `CCD_RST_CH1_CNT;
            ch1_div_q <= `CCD_RST_CH1_DIV;
            ch1_out_q <= `CCD_RST_CH1_OUT;
            // R12: low count resets 0x1
            // R13: high count resets 0x1
            ch2_cnt_q <= `CCD_RST_CH2_CNT;
            ch2_div_q <= `CCD_RST_CH2_DIV;
            rdata_q <= 8'h00;
        end
        else
        begin
            ch1_cnt_q <= ch1_cnt_d;
            ch1_div_q <= ch1_div_d;
            ch1_out_q <= ch1_out_d;
            ch2_cnt_q <= ch2_cnt_d;
            ch2_div_q <= ch2_div_d;
            rdata_q <= rdata_d;
        end
    end

    // ****************************************************************
    // Alignment input and input clock image
    // ****************************************************************
    logic align_n_sync;
    logic align;
    logic clk_img_q;
    logic clk_img_d;

    // The alignment pin is asynchronous to the divider clock.
    ccd_sync2 u_align_sync (
        .clk(clk),
        .rst_n(rst_n),
        .rst_val(1'b1),
        .async_in(align_req_n),
        .sync_out(align_n_sync)
    );

    assign align = ~align_n_sync;

    // A flop cannot carry the clock itself, so a toggle stands in for it.
    always_comb
    begin
        clk_img_d = ~clk_img_q;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clk_img_q <= 1'b0;
        end
        else
        begin
            clk_img_q <= clk_img_d;
        end
    end

    // ****************************************************************
    // Dividers
    // ****************************************************************
    logic ch1_div_out;
    logic ch2_div_out;

    ccd_divider u_ch1_div (
        .clk(clk),
        .rst_n(rst_n),
        .clk_img(clk_img_q),
        .low_cnt(ch1_cnt_q[`CCD_CNT_LOW_HI:`CCD_CNT_LOW_LO]),
        .high_cnt(ch1_cnt_q[`CCD_CNT_HIGH_HI:`CCD_CNT_HIGH_LO]),
        .bypass(ch1_div_q[`CCD_DIV_BYPASS]),
        .ignore_align(ch1_div_q[`CCD_DIV_IGNORE]),
        .force_on(ch1_div_q[`CCD_DIV_FORCE]),
        .start_high(ch1_div_q[`CCD_DIV_START]),
        .phase(ch1_div_q[`CCD_DIV_PHASE_HI:`CCD_DIV_PHASE_LO]),
        .align(align),
        .div_out(ch1_div_out)
    );

    ccd_divider u_ch2_div (
        .clk(clk),
        .rst_n(rst_n),
        .clk_img(clk_img_q),
        .low_cnt(ch2_cnt_q[`CCD_CNT_LOW_HI:`CCD_CNT_LOW_LO]),
        .high_cnt(ch2_cnt_q[`CCD_CNT_HIGH_HI:`CCD_CNT_HIGH_LO]),
        .bypass(ch2_div_q[`CCD_DIV_BYPASS]),
        .ignore_align(ch2_div_q[`CCD_DIV_IGNORE]),
        .force_on(ch2_div_q[`CCD_DIV_FORCE]),
        .start_high(ch2_div_q[`CCD_DIV_START]),
        .phase(ch2_div_q[`CCD_DIV_PHASE_HI:`CCD_DIV_PHASE_LO]),
        .align(align),
        .div_out(ch2_div_out)
    );

    // ****************************************************************
    // Channel 1 output routing
    // ****************************************************************
    logic direct_sel;
    logic pdown;
    logic chan_src;
    logic [2:0] drv_d;
    logic [2:0] drv_q;
    logic drv_en_d;
    logic drv_en_q;
    logic dcc_d;
    logic dcc_q;
    logic ch2_out_d;
    logic ch2_out_q;

    always_comb
    begin
        // R10: direct route unless blocked
        direct_sel = ch1_out_q[`CCD_OUT_DIRECT] & ~direct_route_block;
        pdown = ch1_out_q[`CCD_OUT_PDOWN];
        chan_src = direct_sel ? clk_img_q : ch1_div_out;
        if (pdown)
        begin
            // R9: drivers safely off
            drv_d = 3'h0;
            drv_en_d = 1'b0;
        end
        else
        begin
            // R6: inversion applies unless powered down
            drv_d = {3{chan_src}} ^ driver_invert;
            drv_en_d = 1'b1;
        end
        // R11: correction unless disabled or powered down
        dcc_d = ~ch1_out_q[`CCD_OUT_DCC_DIS] & ~pdown;
        ch2_out_d = ch2_div_out;
    end

    // Output flops add one cycle behind the divider state.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drv_q <= 3'h0;
            drv_en_q <= 1'b0;
            dcc_q <= 1'b0;
            ch2_out_q <= 1'b0;
        end
        else
        begin
            drv_q <= drv_d;
            drv_en_q <= drv_en_d;
            dcc_q <= dcc_d;
            ch2_out_q <= ch2_out_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign group1_driver_a = drv_q[0];
    assign group1_driver_b = drv_q[1];
    assign group1_driver_c = drv_q[2];
    assign group1_driver_en = drv_en_q;
    assign duty_cycle_correction = dcc_q;
    assign channel2_div_out = ch2_out_q;

endmodule : ccd_top
`default_nettype wire

//--- tb/ccd_top_checker.sv
// Port checker for the channel clock divider.
`timescale 1ns/1ps
`default_nettype none
module ccd_top_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic align_req_n,
    input wire logic direct_route_block,
    input wire logic [2:0] driver_invert,
    input wire logic group1_driver_a,
    input wire logic group1_driver_b,
    input wire logic group1_driver_c,
    input wire logic group1_driver_en,
    input wire logic duty_cycle_correction,
    input wire logic channel2_div_out
);
    // ****************************************
    // Register shadows and run counting
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] c2_q, d1_q, o1_q, d2_q;
    logic [2:0] a1_q, a2_q;
    logic [4:0] r2_q;
    logic p2_q, ok2_q, ev2, tg2;
    assign ev2 = (reg_wr && reg_addr[9:1] == 9'h0cb) || !align_req_n;
    assign tg2 = channel2_div_out != p2_q;
    // Ages let config settle, since a run begun mid-write is not clean.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            c2_q <= 8'h11;
            d1_q <= 8'h00;
            o1_q <= 8'h00;
            d2_q <= 8'h00;
            a1_q <= 3'h0;
            a2_q <= 3'h0;
            r2_q <= 5'h00;
            p2_q <= 1'b0;
            ok2_q <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_addr == 10'h196) c2_q <= reg_wdata;
            if (reg_wr && reg_addr == 10'h197) d2_q <= reg_wdata;
            if (reg_wr && reg_addr == 10'h194) d1_q <= reg_wdata;
            if (reg_wr && reg_addr == 10'h195) o1_q <= reg_wdata;
            if ((reg_wr && reg_addr >= 10'h193 && reg_addr <= 10'h195)
                || $changed({driver_invert, direct_route_block}))
                a1_q <= 3'h0;
            else if (a1_q != 3'h7) a1_q <= a1_q + 3'h1;
            if (ev2) a2_q <= 3'h0;
            else if (a2_q != 3'h7) a2_q <= a2_q + 3'h1;
            p2_q <= channel2_div_out;
            if (tg2) r2_q <= 5'h01;
            else if (r2_q != 5'h1f) r2_q <= r2_q + 5'h01;
            ok2_q <= tg2 ? (a2_q == 3'h7 && !ev2) : (ok2_q && !ev2);
        end
    end
    property p_c2_high;
        tg2 && p2_q && ok2_q && d2_q[7:6] == 2'b00
        |-> r2_q == c2_q[3:0] + 5'h01;
    endproperty
    a_c2_high: assert property (p_c2_high)
        else $error("channel 2 high run length wrong");
    property p_c2_low;
        tg2 && !p2_q && ok2_q && d2_q[7:6] == 2'b00
        |-> r2_q == c2_q[7:4] + 5'h01;
    endproperty
    a_c2_low: assert property (p_c2_low)
        else $error("channel 2 low run length wrong");
    property p_en;
        a1_q == 3'h7 |-> group1_driver_en == !o1_q[2];
    endproperty
    a_en: assert property (p_en)
        else $error("driver enable disagrees with power-down");
    property p_pd;
        !group1_driver_en |-> {group1_driver_a, group1_driver_b,
            group1_driver_c} == 3'b000;
    endproperty
    a_pd: assert property (p_pd)
        else $error("drivers active while powered down");
    property p_dcc;
        a1_q == 3'h7 |-> duty_cycle_correction == !(o1_q[0] | o1_q[2]);
    endproperty
    a_dcc: assert property (p_dcc)
        else $error("duty correction state wrong");
    property p_frc;
        a1_q == 3'h7 && d1_q[7:6] == 2'b01 && !o1_q[2]
        && (!o1_q[1] || direct_route_block)
        |-> group1_driver_a == ((d1_q[5] & d1_q[4]) ^ driver_invert[0]);
    endproperty
    a_frc: assert property (p_frc)
        else $error("forced level wrong");
    property p_unused;
        reg_rd && reg_addr == 10'h195 |=> reg_rdata[7:3] == 5'h00;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused control bits read nonzero");
    property p_unmapped;
        reg_rd && (reg_addr < 10'h193 || reg_addr > 10'h197)
        |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read nonzero");
    property p_stand;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_stand: assert property (p_stand)
        else $error("read data changed without a read");
    c_run: cover property (tg2 && ok2_q);
    c_pd: cover property (!group1_driver_en);
    c_byp: cover property (d1_q[7] && a1_q == 3'h7);
endmodule : ccd_top_checker
bind ccd_top ccd_top_checker ccd_top_checker_inst (.clk(clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .align_req_n(align_req_n), .direct_route_block(direct_route_block),
    .driver_invert(driver_invert), .group1_driver_a(group1_driver_a),
    .group1_driver_b(group1_driver_b), .group1_driver_c(group1_driver_c),
    .group1_driver_en(group1_driver_en),
    .duty_cycle_correction(duty_cycle_correction),
    .channel2_div_out(channel2_div_out));
`default_nettype wire

//--- tb/ccd_load.sv
// Clock load model that measures run lengths of one driver.
`timescale 1ns/1ps
`default_nettype none
module ccd_load (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic drv,
    output logic [7:0] hi_len,
    output logic [7:0] lo_len
);
    // ****************************************
    // Run length capture
    // ****************************************
    logic last_q;
    logic [7:0] cnt_q;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_q <= 1'b0;
            cnt_q <= 8'h00;
            hi_len <= 8'h00;
            lo_len <= 8'h00;
        end
        else if (drv !== last_q)
        begin
            if (last_q) hi_len <= cnt_q;
            else lo_len <= cnt_q;
            last_q <= drv;
            cnt_q <= 8'h01;
        end
        else if (cnt_q != 8'hff) cnt_q <= cnt_q + 8'h01;
    end
endmodule : ccd_load
`default_nettype wire

//--- tb/ccd_top_tb.sv
// Self-checking testbench for the channel clock divider.
`timescale 1ns/1ps
`default_nettype none
module ccd_top_tb;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [9:0] reg_addr = 10'h000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, hi_len, lo_len;
    logic align_req_n = 1'b1, direct_route_block = 1'b0;
    logic [2:0] driver_invert = 3'b000;
    logic da, db, dc, den, dcc, c2;
    int bad_count = 0, compares = 0, n0, n3;
    ccd_top ccd_top_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .align_req_n(align_req_n),
        .direct_route_block(direct_route_block),
        .driver_invert(driver_invert), .group1_driver_a(da),
        .group1_driver_b(db), .group1_driver_c(dc),
        .group1_driver_en(den), .duty_cycle_correction(dcc),
        .channel2_div_out(c2));
    ccd_load ccd_load_inst (.clk(clk), .rst_n(rst_n), .drv(da),
        .hi_len(hi_len), .lo_len(lo_len));
    always #5 clk = ~clk;
    task tally_and_finish;
        $display("mismatches %0d of %0d compares", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    task chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    task wr(input logic [9:0] a, input logic [7:0] d);
        wt(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        wt(1);
        reg_wr = 1'b0;
    endtask : wr
    task rd(input logic [9:0] a, input logic [7:0] e);
        wt(1);
        reg_addr = a;
        reg_rd = 1'b1;
        wt(1);
        reg_rd = 1'b0;
        chk(reg_rdata === e, "read data");
    endtask : rd
    task tog;
        logic x;
        // New routing reaches the drivers two edges after the write.
        wt(2);
        repeat (8)
        begin
            x = da;
            wt(1);
            chk(da === ~x && db === da, "toggle");
        end
    endtask : tog
    // Alignment held for 12 cycles, then cycles to first change counted.
    task t_align(input logic [7:0] d, output int n);
        wr(10'h194, d);
        align_req_n = 1'b0;
        wt(4);
        repeat (8)
        begin
            wt(1);
            chk(da === d[4] && c2 === 1'b0, "held level");
        end
        align_req_n = 1'b1;
        n = 0;
        while (da === d[4] && n < 100)
        begin
            wt(1);
            n++;
        end
    endtask : t_align
    task t_reset;
        rd(10'h193, 8'h33);
        rd(10'h194, 8'h00);
        rd(10'h195, 8'h00);
        rd(10'h196, 8'h11);
        rd(10'h197, 8'h00);
        rd(10'h198, 8'h00);
    endtask : t_reset
    task t_counts;
        wt(40);
        chk(hi_len === 8'd4 && lo_len === 8'd4, "reset run");
        wr(10'h193, 8'h52);
        wt(40);
        chk(hi_len === 8'd3 && lo_len === 8'd6, "run");
        chk(db === da && dc === da, "drivers alike");
        wr(10'h193, 8'h00);
        wr(10'h196, 8'h20);
        wt(30);
        chk(hi_len === 8'd1 && lo_len === 8'd1, "min run");
        wr(10'h193, 8'h33);
    endtask : t_counts
    task t_mode;
        t_align(8'h00, n0);
        t_align(8'h03, n3);
        chk(n3 == n0 + 3, "phase delay");
        t_align(8'h10, n0);
        t_align(8'h70, n0);
        chk(n0 == 100, "forced high");
        wr(10'h194, 8'h60);
        wt(4);
        chk(da === 1'b0, "forced low");
        wr(10'h194, 8'hb0);
        tog();
        driver_invert = 3'b111;
        tog();
        driver_invert = 3'b000;
        wr(10'h194, 8'h00);
    endtask : t_mode
    task t_out;
        wr(10'h195, 8'h04);
        wt(4);
        chk(den === 1'b0 && {da, db, dc} === 3'b000, "power-down");
        chk(dcc === 1'b0, "dcc off");
        wr(10'h195, 8'h01);
        wt(4);
        chk(den === 1'b1 && dcc === 1'b0, "dcc disabled");
        wr(10'h195, 8'h02);
        tog();
        direct_route_block = 1'b1;
        wt(30);
        chk(hi_len === 8'd4 && lo_len === 8'd4, "route blocked");
        direct_route_block = 1'b0;
        wr(10'h195, 8'hff);
        rd(10'h195, 8'h07);
        wr(10'h195, 8'h00);
        wt(4);
        chk(dcc === 1'b1, "dcc on");
    endtask : t_out
    initial
    begin
        wt(8);
        rst_n = 1'b1;
        t_reset();
        t_counts();
        t_mode();
        t_out();
        tally_and_finish();
    end
    // A hang counts as a mismatch and ends the run the normal way.
    initial
    begin
        #100us;
        bad_count++;
        tally_and_finish();
    end
endmodule : ccd_top_tb
`default_nettype wire
